// ---- logic/isr_defines.vh ----
/*
 * register offsets, reset values, field positions and the rate-limit constant for the
 * event status block. assumes inclusion by bare name from logic/isr_event_status.v.
 */
// Notes on behaviour
// - each status bit is 1 once its condition has occurred since the last read, otherwise 0.
// - a read returns the bits and clears them, except a bit held in level mode while its source is still true.
// - a bit whose mask enable is clear always reads as 0.
// - after reset the status register is 00.
// - bit 7 sets when the transmitter drops or repeats a sample with no rate converter and an asynchronous clock.
// - bit 7 also sets on each new block-start pulse when that pin is an input and the converter is unused.
// - bit 6 sets when the slave output port with asynchronous frame clock drops or repeats a sample.
// - bit 6 also sets when the converter feeds a slave output port and the clock ratio differs from the selection.
// - bit 5 sets when either sample rate ratio exceeds three.
// - bit 4 sets on left channel converter over-range.
// - an over-ranged output sample saturates to full scale instead of wrapping.
// - bit 3 sets on right channel converter over-range, the sample being clipped.
// - bit 2's source is true while the channel-status buffer moves from stage D to stage E.
// - bit 1's source is true while the channel-status buffer moves from stage E to stage F.
`ifndef ISR_DEFINES_VH
`define ISR_DEFINES_VH
`define ISR_OFF_STATUS 12'h01c
`define ISR_OFF_MASK 12'h040
`define ISR_OFF_MODE 12'h044
`define ISR_OFF_CTRL 12'h048
`define ISR_OFF_RATIO 12'h04c
`define ISR_RST_STATUS 8'h00
`define ISR_RST_MASK 8'h00
`define ISR_RST_MODE 8'h00
`define ISR_RST_CTRL 8'h00
`define ISR_RST_RATIO 8'h00
`define ISR_BIT_TX_SLIP 7
`define ISR_BIT_OUT_SLIP 6
`define ISR_BIT_RATE_EXC 5
`define ISR_BIT_OVRL 4
`define ISR_BIT_OVRR 3
`define ISR_BIT_CBUF_FIRST 2
`define ISR_BIT_CBUF_SECOND 1
`define ISR_BIT_RX_ERR 0
`define ISR_CTRL_SRC_USED 0
`define ISR_CTRL_TBS_INPUT 1
`define ISR_CTRL_OUT_MASTER 2
`define ISR_CTRL_TX_ASYNC 3
`define ISR_CTRL_OUT_ASYNC 4
`define ISR_RATIO_MAX 3
`endif

// ---- logic/isr_event_status.v ----
/*
 * event status register with mask, level/edge mode, clear-on-read and a level interrupt,
 * plus the left/right saturation that feeds the over-range bits and the frame-clock
 * ratio check behind the output slip bit.
 * assumes an apb master on MCLK_I that waits for PREADY_O, event inputs from pins
 * (block start, output frame clock) that are asynchronous and synchronised here,
 * and event inputs from core logic already on MCLK_I.
 * unmapped addresses read as zero and ignore writes.
 */
`timescale 1ns/1ps
`default_nettype none
`include "isr_defines.vh"
module isr_event_status #(
    parameter SW = 24,
    parameter RW = 8
) (
    // clock and reset
    input wire MCLK_I,
    input wire RSTN_I,
    // apb slave
    input wire PSEL_I,
    input wire PENABLE_I,
    input wire PWRITE_I,
    input wire [11:0] PADDR_I,
    input wire [31:0] PWDATA_I,
    output wire [31:0] PRDATA_O,
    output wire PREADY_O,
    output wire PSLVERR_O,
    // pin events, asynchronous
    input wire TRANSMIT_BLOCK_START_I,
    input wire OUTPUT_FRAME_CLOCK_I,
    // core events, on MCLK_I
    input wire TX_SAMPLE_SLIP_I,
    input wire OUT_SAMPLE_SLIP_I,
    input wire [7:0] OUT_CLOCK_RATIO_I,
    input wire [RW-1:0] RATE_IN_TO_OUT_I,
    input wire [RW-1:0] RATE_OUT_TO_IN_I,
    input wire signed [SW:0] LEFT_SUM_I,
    input wire signed [SW:0] RIGHT_SUM_I,
    input wire CBUF_D_TO_E_I,
    input wire CBUF_E_TO_F_I,
    input wire RECEIVER_ERROR_I,
    // results
    output wire signed [SW-1:0] LEFT_SAMPLE_O,
    output wire signed [SW-1:0] RIGHT_SAMPLE_O,
    output wire IRQ_O
);
////////////////////////////////////////////////////////////////////////////////
reg [7:0] status_r;
reg [7:0] mask_r;
reg [7:0] mode_r;
reg [7:0] ctrl_r;
reg [7:0] ratio_r;
reg [7:0] src_prev_r;
reg [31:0] prdata_r;
reg pready_r;
reg irq_r;
reg [2:0] tbs_sync_r;
reg [2:0] ofc_sync_r;
reg tbs_state_r;
reg ofc_state_r;
reg [7:0] frame_cnt_r;
reg ratio_bad_r;
reg signed [SW-1:0] left_r;
reg signed [SW-1:0] right_r;
reg pslverr_r;
wire setup = PSEL_I & ~PENABLE_I;
wire wr_hit = setup & PWRITE_I;
wire rd_hit = setup & ~PWRITE_I;
wire rd_status = setup & ~PWRITE_I & (PADDR_I == `ISR_OFF_STATUS);
wire src_used = ctrl_r[`ISR_CTRL_SRC_USED];
wire out_slave = ~ctrl_r[`ISR_CTRL_OUT_MASTER];
wire tbs_agree = (tbs_sync_r[1] == tbs_sync_r[2]);
wire ofc_agree = (ofc_sync_r[1] == ofc_sync_r[2]);
wire tbs_rise = tbs_agree & tbs_sync_r[2] & ~tbs_state_r;
wire ofc_rise = ofc_agree & ofc_sync_r[2] & ~ofc_state_r;
////////////////////////////////////////////////////////////////////////////////
// saturate an over-ranged sum to full scale
function [SW-1:0] clip;
    input [SW:0] s;
    begin
        if (s[SW] != s[SW-1])
            clip = s[SW] ? {1'b1, {(SW-1){1'b0}}} : {1'b0, {(SW-1){1'b1}}};
        else
            clip = s[SW-1:0];
    end
endfunction
////////////////////////////////////////////////////////////////////////////////
// event sources, one wire per condition
// transmitter slip and block start share bit 7
wire tx_slip_ev = ~src_used & ctrl_r[`ISR_CTRL_TX_ASYNC] & TX_SAMPLE_SLIP_I;
wire tx_block_ev = ~src_used & ctrl_r[`ISR_CTRL_TBS_INPUT] & tbs_rise;
// output port slip and ratio mismatch share bit 6
wire out_slip_ev = out_slave & ctrl_r[`ISR_CTRL_OUT_ASYNC] & OUT_SAMPLE_SLIP_I;
wire out_ratio_ev = src_used & out_slave & ratio_bad_r;
// either direction of the rate ratio
wire rate_fwd_ev = (RATE_IN_TO_OUT_I > `ISR_RATIO_MAX);
wire rate_back_ev = (RATE_OUT_TO_IN_I > `ISR_RATIO_MAX);
// top two bits of a sum differ on over-range
wire left_ovr_ev = (LEFT_SUM_I[SW] != LEFT_SUM_I[SW-1]);
wire right_ovr_ev = (RIGHT_SUM_I[SW] != RIGHT_SUM_I[SW-1]);
reg [7:0] src;
always @*
begin
    src = 8'h00;
    src[`ISR_BIT_TX_SLIP] = tx_slip_ev | tx_block_ev;
    src[`ISR_BIT_OUT_SLIP] = out_slip_ev | out_ratio_ev;
    src[`ISR_BIT_RATE_EXC] = rate_fwd_ev | rate_back_ev;
    src[`ISR_BIT_OVRL] = left_ovr_ev;
    src[`ISR_BIT_OVRR] = right_ovr_ev;
    src[`ISR_BIT_CBUF_FIRST] = CBUF_D_TO_E_I;
    src[`ISR_BIT_CBUF_SECOND] = CBUF_E_TO_F_I;
    src[`ISR_BIT_RX_ERR] = RECEIVER_ERROR_I;
end
////////////////////////////////////////////////////////////////////////////////
// block-start pin: three flops, a level counts once the last two agree
always @(posedge MCLK_I or negedge RSTN_I)
begin
    if (!RSTN_I)
    begin
        tbs_sync_r <= 3'h0;
        tbs_state_r <= 1'b0;
    end
    else
    begin
        tbs_sync_r <= {tbs_sync_r[1:0], TRANSMIT_BLOCK_START_I};
        if (tbs_agree)
        begin
            tbs_state_r <= tbs_sync_r[2];
        end
    end
end
////////////////////////////////////////////////////////////////////////////////
// output frame clock pin: three flops, a level counts once the last two agree
always @(posedge MCLK_I or negedge RSTN_I)
begin
    if (!RSTN_I)
    begin
        ofc_sync_r <= 3'h0;
        ofc_state_r <= 1'b0;
    end
    else
    begin
        ofc_sync_r <= {ofc_sync_r[1:0], OUTPUT_FRAME_CLOCK_I};
        if (ofc_agree)
        begin
            ofc_state_r <= ofc_sync_r[2];
        end
    end
end
////////////////////////////////////////////////////////////////////////////////
// frame clock period in MCLK cycles against the expected ratio;
// the first rise after reset only starts the count, so no false mismatch
reg frame_seen_r;
always @(posedge MCLK_I or negedge RSTN_I)
begin
    if (!RSTN_I)
    begin
        frame_cnt_r <= 8'h00;
        frame_seen_r <= 1'b0;
        ratio_bad_r <= 1'b0;
    end
    else
    begin
        ratio_bad_r <= 1'b0;
        if (ofc_rise)
        begin
            frame_cnt_r <= 8'h01;
            frame_seen_r <= 1'b1;
            ratio_bad_r <= frame_seen_r & (frame_cnt_r != OUT_CLOCK_RATIO_I) & (OUT_CLOCK_RATIO_I != 8'h00);
        end
        else if (frame_cnt_r != 8'hff)
        begin
            frame_cnt_r <= frame_cnt_r + 8'h01;
        end
    end
end
////////////////////////////////////////////////////////////////////////////////
// status bits, one per source
wire [7:0] status_nxt;
genvar gi;
generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_bit
        // edge mode wants a rise, level mode the plain source
        wire hit = mode_r[gi] ? src[gi] : (src[gi] & ~src_prev_r[gi]);
        // a status read clears the bit unless level mode still sees the source
        wire keep = status_r[gi] & ~(rd_status & ~(mode_r[gi] & src[gi]));
        // a new event in the clearing cycle wins over the clear
        assign status_nxt[gi] = mask_r[gi] & (hit | keep);
    end
endgenerate
////////////////////////////////////////////////////////////////////////////////
// status and source history
always @(posedge MCLK_I or negedge RSTN_I)
begin
    if (!RSTN_I)
    begin
        status_r <= `ISR_RST_STATUS;
        src_prev_r <= 8'h00;
    end
    else
    begin
        status_r <= status_nxt;
        src_prev_r <= src;
    end
end
////////////////////////////////////////////////////////////////////////////////
// level interrupt, high in the same cycle as the status it follows
always @(posedge MCLK_I or negedge RSTN_I)
begin
    if (!RSTN_I)
    begin
        irq_r <= 1'b0;
    end
    else
    begin
        irq_r <= |status_nxt;
    end
end
////////////////////////////////////////////////////////////////////////////////
// configuration registers, written in the setup cycle
always @(posedge MCLK_I or negedge RSTN_I)
begin
    if (!RSTN_I)
    begin
        mask_r <= `ISR_RST_MASK;
        mode_r <= `ISR_RST_MODE;
        ctrl_r <= `ISR_RST_CTRL;
        ratio_r <= `ISR_RST_RATIO;
    end
    else if (wr_hit)
    begin
        case (PADDR_I)
            `ISR_OFF_MASK: mask_r <= PWDATA_I[7:0];
            `ISR_OFF_MODE: mode_r <= PWDATA_I[7:0];
            `ISR_OFF_CTRL: ctrl_r <= PWDATA_I[7:0];
            `ISR_OFF_RATIO: ratio_r <= PWDATA_I[7:0];
            default:
            begin
            end
        endcase
    end
end
////////////////////////////////////////////////////////////////////////////////
// read data, latched in the setup cycle and held until the next read
always @(posedge MCLK_I or negedge RSTN_I)
begin
    if (!RSTN_I)
    begin
        prdata_r <= 32'h00000000;
    end
    else if (rd_hit)
    begin
        case (PADDR_I)
            `ISR_OFF_STATUS: prdata_r <= {24'h000000, status_r & mask_r};
            `ISR_OFF_MASK: prdata_r <= {24'h000000, mask_r};
            `ISR_OFF_MODE: prdata_r <= {24'h000000, mode_r};
            `ISR_OFF_CTRL: prdata_r <= {24'h000000, ctrl_r};
            `ISR_OFF_RATIO: prdata_r <= {24'h000000, ratio_r};
            default: prdata_r <= 32'h00000000;
        endcase
    end
end
////////////////////////////////////////////////////////////////////////////////
// ready in the access phase, one cycle after every setup; no error is ever given
always @(posedge MCLK_I or negedge RSTN_I)
begin
    if (!RSTN_I)
    begin
        pready_r <= 1'b0;
        pslverr_r <= 1'b0;
    end
    else
    begin
        pready_r <= setup;
        pslverr_r <= 1'b0;
    end
end
////////////////////////////////////////////////////////////////////////////////
// saturated samples, one cycle behind the sums
always @(posedge MCLK_I or negedge RSTN_I)
begin
    if (!RSTN_I)
    begin
        left_r <= {SW{1'b0}};
        right_r <= {SW{1'b0}};
    end
    else
    begin
        left_r <= clip(LEFT_SUM_I);
        right_r <= clip(RIGHT_SUM_I);
    end
end
assign PRDATA_O = prdata_r;
assign PREADY_O = pready_r;
assign PSLVERR_O = pslverr_r;
assign IRQ_O = irq_r;
assign LEFT_SAMPLE_O = left_r;
assign RIGHT_SAMPLE_O = right_r;
endmodule // isr_event_status
`default_nettype wire

// ---- dv/isr_checker.sv ----
/* checker: apb answer, reset, mask, irq and saturation of isr_event_status.
   assumes the bind below attaches it to the top module's ports by name. */
`timescale 1ns/1ps
`default_nettype none
`include "isr_defines.vh"
module isr_checker #(parameter SW = 24) (
    // clock, reset and apb
    input wire logic MCLK_I,
    input wire logic RSTN_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic PREADY_O,
    input wire logic [31:0] PRDATA_O,
    // events and results
    input wire logic signed [SW:0] LEFT_SUM_I,
    input wire logic signed [SW:0] RIGHT_SUM_I,
    input wire logic CBUF_D_TO_E_I,
    input wire logic signed [SW-1:0] LEFT_SAMPLE_O,
    input wire logic signed [SW-1:0] RIGHT_SAMPLE_O,
    input wire logic IRQ_O
);
    logic [7:0] msk_r;
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (!RSTN_I);
    sequence s_setup; PSEL_I && !PENABLE_I; endsequence
    sequence s_rd_st; s_setup ##0 (!PWRITE_I && PADDR_I == `ISR_OFF_STATUS); endsequence
    ////////////////////////////////////////////////////////////////////////////////
    // copy of the mask register, taken at the setup edge like the design
    always_ff @(posedge MCLK_I or negedge RSTN_I)
        if (!RSTN_I)
            msk_r <= 8'h00;
        else if (PSEL_I && !PENABLE_I && PWRITE_I && PADDR_I == `ISR_OFF_MASK)
            msk_r <= PWDATA_I[7:0];
    ////////////////////////////////////////////////////////////////////////////////
    AST_READY: assert property (s_setup |=> PREADY_O ##1 !PREADY_O)
        else $error("ready not one cycle after setup");
    AST_RST: assert property (!$past(RSTN_I) |-> !IRQ_O && !PREADY_O)
        else $error("outputs set after reset");
    AST_MASK: assert property (s_rd_st |=> (PRDATA_O[7:0] & ~$past(msk_r)) == 8'h00)
        else $error("masked bit read as one");
    AST_OVRL: assert property ($rose(LEFT_SUM_I[SW] != LEFT_SUM_I[SW-1]) && msk_r[4] |=> IRQ_O)
        else $error("left overrange gave no irq");
    AST_CBUF: assert property ($rose(CBUF_D_TO_E_I) && msk_r[2] |=> IRQ_O)
        else $error("buffer transfer gave no irq");
    AST_SATL: assert property (LEFT_SUM_I[SW] != LEFT_SUM_I[SW-1] |=>
        LEFT_SAMPLE_O == {$past(LEFT_SUM_I[SW]), {(SW-1){!$past(LEFT_SUM_I[SW])}}}) else $error("left not clipped");
    AST_PASSL: assert property (LEFT_SUM_I[SW] == LEFT_SUM_I[SW-1] |=>
        LEFT_SAMPLE_O == $past(LEFT_SUM_I[SW-1:0])) else $error("left sample altered");
    AST_SATR: assert property (RIGHT_SUM_I[SW] != RIGHT_SUM_I[SW-1] |=>
        RIGHT_SAMPLE_O == {$past(RIGHT_SUM_I[SW]), {(SW-1){!$past(RIGHT_SUM_I[SW])}}}) else $error("right not clipped");
endmodule // isr_checker
bind isr_event_status isr_checker #(.SW(SW)) u_chk (.*);
`default_nettype wire

// ---- dv/isr_event_status_tb.sv ----
/* bench for isr_event_status: event table, then clipping, reset, mask, pin and mode cases.
   assumes the checker is bound to the design. */
`timescale 1ns/1ps
`default_nettype none
`include "isr_defines.vh"
module isr_event_status_tb;
    logic clk = '0, rstn = '0, psel = '0, pen = '0, pw = '0, tbs = '0, ng = '0;
    logic [11:0] pa = '0;
    logic [31:0] pd = '0, q;
    logic [7:0] ev = '0, rat = '0, rot = 8'h01;
    logic ofc = '0;
    logic [15:0] rows [8] = '{16'h8080, 16'h4040, 16'h2020, 16'h1010, 16'h0808, 16'h0404, 16'h0202, 16'h0101};
    int n_fail = 0, n_compared = 0;
    wire [31:0] prd;
    wire [23:0] ls;
    wire prdy, irq;
    always #50 clk = ~clk;
    isr_event_status DUT (.MCLK_I(clk), .RSTN_I(rstn), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pw),
        .PADDR_I(pa), .PWDATA_I(pd), .PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(),
        .TRANSMIT_BLOCK_START_I(tbs), .OUTPUT_FRAME_CLOCK_I(ofc), .TX_SAMPLE_SLIP_I(ev[7]),
        .OUT_SAMPLE_SLIP_I(ev[6]), .OUT_CLOCK_RATIO_I(rat), .RATE_IN_TO_OUT_I(ev[5] ? 8'h04 : 8'h03),
        .RATE_OUT_TO_IN_I(rot), .LEFT_SUM_I(ev[4] ? 25'h0800000 : {ng, 24'h0}),
        .RIGHT_SUM_I(ev[3] ? 25'h0800000 : 25'h0), .CBUF_D_TO_E_I(ev[2]), .CBUF_E_TO_F_I(ev[1]),
        .RECEIVER_ERROR_I(ev[0]), .LEFT_SAMPLE_O(ls), .RIGHT_SAMPLE_O(), .IRQ_O(irq));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic fail(input string m);
        n_fail++;
        $display("CHECK FAILED %0t %s", $time, m);
    endtask
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) fail("value mismatch");
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pw <= w;
        pa <= a;
        pd <= {24'h0, d};
        @(posedge clk);
        pen <= 1'h1;
        do @(posedge clk); while (prdy !== 1'h1);
        q = prd;
        psel <= 1'h0;
        pen <= 1'h0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        apb(1'h0, a, 8'h00);
        cmp(q, {24'h0, e});
    endtask
    // three frame clock periods of ten cycles against expected ratio r
    task automatic frames(input logic [7:0] r);
        rat <= r;
        repeat (3)
        begin
            ofc <= 1'h1;
            repeat (5) @(posedge clk);
            ofc <= 1'h0;
            repeat (5) @(posedge clk);
        end
    endtask
    task automatic results;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (2) @(posedge clk);
        rstn <= 1'h1;
        apb(1'h1, `ISR_OFF_CTRL, 8'h18);
        apb(1'h1, `ISR_OFF_MASK, 8'hff);
        foreach (rows[i])
        begin
            ev <= rows[i][15:8];
            @(posedge clk);
            ev <= 8'h00;
            repeat (2) @(posedge clk);
            cmp(irq, 1'h1);
            rd(`ISR_OFF_STATUS, rows[i][7:0]);
            rd(`ISR_OFF_STATUS, 8'h00);
            cmp(irq, 1'h0);
            $display("row %0d done", i);
        end
        ng <= 1'h1;
        repeat (2) @(posedge clk);
        cmp(ls, 24'h800000);
        ng <= 1'h0;
        rstn <= 1'h0;
        @(posedge clk);
        rstn <= 1'h1;
        rd(`ISR_OFF_STATUS, 8'h00);
        apb(1'h1, `ISR_OFF_CTRL, 8'h1a);
        apb(1'h1, `ISR_OFF_MASK, 8'hf7);
        ev <= 8'h08;
        tbs <= 1'h1;
        @(posedge clk);
        ev <= 8'h00;
        repeat (8) @(posedge clk);
        rd(`ISR_OFF_STATUS, 8'h80);
        apb(1'h1, `ISR_OFF_MODE, 8'h04);
        ev <= 8'h05;
        repeat (2) @(posedge clk);
        rd(`ISR_OFF_STATUS, 8'h05);
        rd(`ISR_OFF_STATUS, 8'h04);
        ev <= 8'h00;
        rd(12'h000, 8'h00);
        rd(`ISR_OFF_STATUS, 8'h04);
        apb(1'h1, `ISR_OFF_CTRL, 8'h01);
        frames(8'h0a);
        rd(`ISR_OFF_STATUS, 8'h00);
        frames(8'h08);
        rd(`ISR_OFF_STATUS, 8'h40);
        rot <= 8'h04;
        @(posedge clk);
        rot <= 8'h01;
        repeat (2) @(posedge clk);
        rd(`ISR_OFF_STATUS, 8'h20);
        $display("hand cases done");
        results;
    end
    initial
    begin
        #100us;
        fail("timeout");
        results;
    end
endmodule // isr_event_status_tb
`default_nettype wire
